//--- core/dsmp_ctrl.v
// Status word, operation mode and profile position setpoint control
`timescale 1ns/100ps
`include "dsmp_regs.vh"

module dsmp_ctrl #(
    parameter CSX_EN = 1
) (
    // Clock and reset
    input wire ref_clk,
    input wire arst_n,
    // Object dictionary access
    input wire od_wr,
    input wire od_rd,
    input wire [15:0] od_index,
    input wire [7:0] od_sub,
    input wire [31:0] od_wdata,
    output reg [31:0] od_rdata,
    output reg od_ack,
    output reg od_err,
    // Drive state and conditions
    input wire [2:0] drv_state,
    input wire fault_cond,
    input wire warn_cond,
    input wire volt_on,
    input wire [7:0] control_source_selector,
    input wire cw_processed,
    input wire [3:0] qs_option,
    input wire qs_done,
    input wire limit_in,
    // Trajectory feedback
    input wire [31:0] act_pos,
    input wire traj_at_target,
    input wire standstill,
    input wire follow_err,
    input wire vel_reached,
    input wire zero_speed,
    input wire slip_err,
    input wire home_done,
    input wire home_err,
    input wire ip_active,
    input wire tgt_ignored,
    // Trajectory command
    output reg [31:0] traj_target,
    output reg traj_start,
    output reg traj_halt,
    output reg move_busy,
    output reg [31:0] traj_vel,
    output reg [31:0] traj_acc,
    output reg [31:0] traj_dec,
    output reg [31:0] traj_qs_dec,
    output reg [7:0] traj_dir_inv,
    // Status and mode
    output reg [15:0] status_word,
    output reg [7:0] mode_disp
);

    reg [15:0] ctrl_q;
    reg [7:0] mode_req_q;
    reg [31:0] tgt_q;
    reg [31:0] lim_min_q;
    reg [31:0] lim_max_q;
    reg new_sp_q;
    reg ack_q;
    reg pend_q;
    reg [31:0] pend_pos_q;
    reg qs_end_q;

    wire in_pp = (mode_disp == `DSMP_MODE_PP);
    wire op_en = (drv_state == `DSMP_ST_OP_EN);
    wire cw_new_sp = ctrl_q[`DSMP_CW_NEW_SP];
    wire cw_chg_imm = ctrl_q[`DSMP_CW_CHG_IMM];
    wire cw_rel = ctrl_q[`DSMP_CW_REL];
    wire cw_halt = ctrl_q[`DSMP_CW_HALT];
    wire new_sp_rise = cw_new_sp & ~new_sp_q;

    // Relative targets build on the last commanded position while a move runs, else on act_pos
    wire [31:0] sp_base = move_busy ? traj_target : act_pos;
    // Carry dropped on purpose: relative moves wrap like the position count
    wire [32:0] sp_sum = {1'b0, sp_base} + {1'b0, tgt_q};
    wire [31:0] sp_abs = cw_rel ? sp_sum[31:0] : tgt_q;

    // Mode code validity; cyclic codes only when built in
    reg mode_ok;
    always @* begin
        case (od_wdata[7:0])
            `DSMP_MODE_PP,
            `DSMP_MODE_VL,
            `DSMP_MODE_PV,
            `DSMP_MODE_HM,
            `DSMP_MODE_IP: mode_ok = 1'b1;
            `DSMP_MODE_CSP,
            `DSMP_MODE_CSV,
            `DSMP_MODE_CST: mode_ok = (CSX_EN != 0);
            default: mode_ok = 1'b0;
        endcase
    end

    // Object dictionary read mux and map check
    reg [31:0] rd_mux;
    reg hit;
    reg wr_ok;
    always @* begin
        rd_mux = `DSMP_RST_WORD;
        hit = 1'b1;
        wr_ok = 1'b1;
        case (od_index)
            `DSMP_OD_CTRL_WORD: rd_mux = {16'h0000, ctrl_q};
            `DSMP_OD_STAT_WORD: begin
                rd_mux = {16'h0000, status_word};
                wr_ok = 1'b0;
            end
            `DSMP_OD_MODE_SEL: begin
                rd_mux = {24'h00_0000, mode_req_q};
                wr_ok = mode_ok;
            end
            `DSMP_OD_MODE_DISP: begin
                rd_mux = {24'h00_0000, mode_disp};
                wr_ok = 1'b0;
            end
            `DSMP_OD_ACT_POS: begin
                rd_mux = act_pos;
                wr_ok = 1'b0;
            end
            `DSMP_OD_TGT_POS: rd_mux = tgt_q;
            `DSMP_OD_SOFT_LIM: begin
                if (od_sub == `DSMP_SUB_LIM_MIN) begin
                    rd_mux = lim_min_q;
                end else if (od_sub == `DSMP_SUB_LIM_MAX) begin
                    rd_mux = lim_max_q;
                end else begin
                    hit = 1'b0;
                end
            end
            `DSMP_OD_DIR_INV: rd_mux = {24'h00_0000, traj_dir_inv};
            `DSMP_OD_MOVE_VEL: rd_mux = traj_vel;
            `DSMP_OD_MOVE_ACC: rd_mux = traj_acc;
            `DSMP_OD_MOVE_DEC: rd_mux = traj_dec;
            `DSMP_OD_ESTOP_DEC: rd_mux = traj_qs_dec;
            default: hit = 1'b0;
        endcase
    end

    wire wr_go = od_wr & hit & wr_ok;

    // Access answer one cycle after the strobe
    // Read data stays until the next good read, so a slow master may fetch it late
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            od_rdata <= `DSMP_RST_WORD;
            od_ack <= 1'b0;
            od_err <= 1'b0;
        end else begin
            od_ack <= (od_wr | od_rd) & hit & (od_rd | wr_ok);
            od_err <= (od_wr | od_rd) & ~(hit & (od_rd | wr_ok));
            if (od_rd & hit) begin
                od_rdata <= rd_mux;
            end
        end
    end

    // Writable objects
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= `DSMP_RST_CTRL;
            mode_req_q <= `DSMP_RST_MODE;
            tgt_q <= `DSMP_RST_WORD;
            lim_min_q <= `DSMP_RST_WORD;
            lim_max_q <= `DSMP_RST_WORD;
            traj_dir_inv <= `DSMP_RST_BYTE;
            traj_vel <= `DSMP_RST_WORD;
            traj_acc <= `DSMP_RST_WORD;
            traj_dec <= `DSMP_RST_WORD;
            traj_qs_dec <= `DSMP_RST_WORD;
        end else if (wr_go) begin
            // Refused accesses never get here, so nothing is half written
            case (od_index)
                `DSMP_OD_CTRL_WORD: ctrl_q <= od_wdata[15:0];
                `DSMP_OD_MODE_SEL: mode_req_q <= od_wdata[7:0];
                `DSMP_OD_TGT_POS: tgt_q <= od_wdata;
                `DSMP_OD_SOFT_LIM: begin
                    if (od_sub == `DSMP_SUB_LIM_MIN) begin
                        lim_min_q <= od_wdata;
                    end else begin
                        // Only sub-index 2 can reach here
                        lim_max_q <= od_wdata;
                    end
                end
                `DSMP_OD_DIR_INV: traj_dir_inv <= od_wdata[7:0];
                `DSMP_OD_MOVE_VEL: traj_vel <= od_wdata;
                `DSMP_OD_MOVE_ACC: traj_acc <= od_wdata;
                `DSMP_OD_MOVE_DEC: traj_dec <= od_wdata;
                `DSMP_OD_ESTOP_DEC: traj_qs_dec <= od_wdata;
                default: ctrl_q <= ctrl_q;
            endcase
        end
    end

    // Mode in effect follows the request only while operation is enabled,
    // so a switch never lands in the middle of a stop or fault reaction
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_disp <= `DSMP_RST_MODE;
        end else if (op_en) begin
            mode_disp <= mode_req_q;
        end
    end

    // Halt is a level to the trajectory; decel profile applied there
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            traj_halt <= 1'b0;
        end else begin
            traj_halt <= cw_halt;
        end
    end

    // Profile position setpoint handling.
    // One pending slot queues the next move while one runs.
    wire run_pp = in_pp & op_en;
    wire take = run_pp & new_sp_rise & ~ack_q;
    wire direct = take & (cw_chg_imm | ~move_busy);
    wire queue = take & ~direct;
    // Arrival is ignored in the start cycle, while the trajectory still
    // reports the previous target
    wire arrive = move_busy & traj_at_target & ~traj_start;

    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            new_sp_q <= 1'b0;
            ack_q <= 1'b0;
            pend_q <= 1'b0;
            pend_pos_q <= `DSMP_RST_WORD;
            traj_target <= `DSMP_RST_WORD;
            traj_start <= 1'b0;
            move_busy <= 1'b0;
        end else begin
            new_sp_q <= cw_new_sp;
            traj_start <= 1'b0;
            if (!run_pp) begin
                pend_q <= 1'b0;
                ack_q <= 1'b0;
                move_busy <= 1'b0;
            end else begin
                if (direct) begin
                    // Absolute or relative move in position control
                    traj_target <= sp_abs;
                    traj_start <= 1'b1;
                    move_busy <= 1'b1;
                    pend_q <= 1'b0;
                end else if (queue) begin
                    pend_pos_q <= sp_abs;
                    pend_q <= 1'b1;
                end else if (arrive && pend_q) begin
                    // Carry straight on to the stored target
                    traj_target <= pend_pos_q;
                    traj_start <= 1'b1;
                    pend_q <= 1'b0;
                end else if (arrive) begin
                    move_busy <= 1'b0;
                end
                if (take) begin
                    ack_q <= 1'b1;
                end else if (!cw_new_sp && !pend_q) begin
                    // Ack held while the slot is full, stalling the master
                    ack_q <= 1'b0;
                end
            end
        end
    end

    // Quick stop end is remembered until the state leaves quick stop
    // Other options leave bit 10 to its normal sources
    wire qs_opt_hit = (qs_option >= `DSMP_QS_OPT_LO) &&
        (qs_option <= `DSMP_QS_OPT_HI);
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            qs_end_q <= 1'b0;
        end else if (drv_state != `DSMP_ST_QS_ACT) begin
            qs_end_q <= 1'b0;
        end else if (qs_done && qs_opt_hit) begin
            qs_end_q <= 1'b1;
        end
    end

    // State bits
    reg [6:0] st_enc;
    always @* begin
        case (drv_state)
            `DSMP_ST_NOT_RDY: st_enc = `DSMP_ENC_NOT_RDY;
            `DSMP_ST_SOD: st_enc = `DSMP_ENC_SOD;
            `DSMP_ST_RTSO: st_enc = `DSMP_ENC_RTSO;
            `DSMP_ST_SW_ON: st_enc = `DSMP_ENC_SW_ON;
            `DSMP_ST_OP_EN: st_enc = `DSMP_ENC_OP_EN;
            `DSMP_ST_QS_ACT: st_enc = `DSMP_ENC_QS_ACT;
            `DSMP_ST_FR_ACT: st_enc = `DSMP_ENC_FR_ACT;
            default: st_enc = `DSMP_ENC_FAULT;
        endcase
    end

    // Target reached per mode
    reg reached;
    always @* begin
        if (qs_end_q) begin
            reached = 1'b1;
        end else if (cw_halt) begin
            // While halted, bit 10 means the axis has stopped
            reached = standstill;
        end else if (in_pp) begin
            // Falls at each take-over, so it tracks setpoint changes
            reached = op_en & ~move_busy & ~traj_start;
        end else begin
            reached = vel_reached;
        end
    end

    // Position modes also flag the soft travel window
    // Equal limits switch the window off
    wire lim_set = (lim_max_q != lim_min_q);
    wire pos_out = lim_set & (($signed(act_pos) < $signed(lim_min_q)) |
        ($signed(act_pos) > $signed(lim_max_q)));
    wire pos_mode = in_pp | (mode_disp == `DSMP_MODE_IP) |
        (mode_disp == `DSMP_MODE_CSP);
    wire limit = limit_in | (pos_mode & pos_out);

    // Mode specific bits 12 and 13
    reg [1:0] oms;
    always @* begin
        case (mode_disp)
            `DSMP_MODE_PP: oms = {follow_err, ack_q};
            `DSMP_MODE_PV: oms = {slip_err, zero_speed};
            `DSMP_MODE_HM: oms = {home_err, home_done};
            `DSMP_MODE_IP: oms = {1'b0, ip_active};
            `DSMP_MODE_CSP: oms = {follow_err, tgt_ignored};
            `DSMP_MODE_CSV,
            `DSMP_MODE_CST: oms = {1'b0, tgt_ignored};
            // Velocity mode and reserved codes carry no mode bits
            default: oms = 2'b00;
        endcase
    end

    // Status word assembly
    reg [15:0] sw_d;
    always @* begin
        // Bits 8, 14 and 15 stay zero
        sw_d = `DSMP_RST_STAT;
        sw_d[6:0] = st_enc;
        sw_d[`DSMP_SW_VOLT] = volt_on;
        if (fault_cond) begin
            sw_d[`DSMP_SW_FAULT] = 1'b1;
        end
        if (drv_state == `DSMP_ST_QS_ACT) begin
            sw_d[`DSMP_SW_QSTOP] = 1'b0;
        end
        // Warning is display only; drv_state never sees it
        sw_d[`DSMP_SW_WARN] = warn_cond;
        sw_d[`DSMP_SW_REMOTE] = cw_processed &
            (control_source_selector == `DSMP_SRC_FIELDBUS);
        sw_d[`DSMP_SW_REACHED] = reached;
        sw_d[`DSMP_SW_LIMIT] = limit;
        sw_d[`DSMP_SW_OMS1:`DSMP_SW_OMS0] = oms;
    end

    // Registered so the master never sees a half updated word
    always @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            status_word <= `DSMP_RST_STAT;
        end else begin
            status_word <= sw_d;
        end
    end

endmodule

//--- core/dsmp_regs.vh
// Object indices, field positions, reset values and mode codes for dsmp_ctrl
// Summary of operation
// - Status bit 5 low during quick stop
// - Ready to operate shows bits 0-2 set
// - Fault condition sets fault status bit
// - Bit 7 warns, never changes state
// - Remote bit needs fieldbus source and processing
// - Target reached set, re-evaluated on setpoint change
// - Finished quick stop options 5-8 set reached
// - Stop request at standstill sets reached
// - Bit 11 internal limit, mode dependent
// - Bits 12-13 meaning chosen by mode
// - Master writes mode select, switch accepted
// - Read-only display shows mode in effect
// - Decode mode codes 1-10, reserved 4-5
// - Set of setpoints: continue without stopping
// - Single setpoint: halt, signal, await new
// - Mode 1 runs absolute or relative moves
// - Control bit 4 takes over target
// - Control bit 5 finish or interrupt move
// - Control bit 6 absolute or relative
// - Control bit 8 halts with deceleration
// - Bit timing governs take-over and queuing
// - Setpoint acknowledge four-step handshake order
// - State encoded in status bits 0-3,5,6
`ifndef DSMP_REGS_VH
`define DSMP_REGS_VH

// Object dictionary indices
`define DSMP_OD_CTRL_WORD 16'h6040
`define DSMP_OD_STAT_WORD 16'h6041
`define DSMP_OD_MODE_SEL 16'h6060
`define DSMP_OD_MODE_DISP 16'h6061
`define DSMP_OD_ACT_POS 16'h6064
`define DSMP_OD_TGT_POS 16'h607a
`define DSMP_OD_SOFT_LIM 16'h607d
`define DSMP_OD_DIR_INV 16'h607e
`define DSMP_OD_MOVE_VEL 16'h6081
`define DSMP_OD_MOVE_ACC 16'h6083
`define DSMP_OD_MOVE_DEC 16'h6084
`define DSMP_OD_ESTOP_DEC 16'h6085

// Soft limit sub-indices
`define DSMP_SUB_LIM_MIN 8'h01
`define DSMP_SUB_LIM_MAX 8'h02

// Control word bits
`define DSMP_CW_NEW_SP 4
`define DSMP_CW_CHG_IMM 5
`define DSMP_CW_REL 6
`define DSMP_CW_HALT 8

// Status word bits
`define DSMP_SW_FAULT 3
`define DSMP_SW_VOLT 4
`define DSMP_SW_QSTOP 5
`define DSMP_SW_WARN 7
`define DSMP_SW_REMOTE 9
`define DSMP_SW_REACHED 10
`define DSMP_SW_LIMIT 11
`define DSMP_SW_OMS0 12
`define DSMP_SW_OMS1 13

// Reset values
`define DSMP_RST_STAT 16'h0000
`define DSMP_RST_CTRL 16'h0000
`define DSMP_RST_MODE 8'h00
`define DSMP_RST_WORD 32'h0000_0000
`define DSMP_RST_BYTE 8'h00

// Device state codes on drv_state
`define DSMP_ST_NOT_RDY 3'h0
`define DSMP_ST_SOD 3'h1
`define DSMP_ST_RTSO 3'h2
`define DSMP_ST_SW_ON 3'h3
`define DSMP_ST_OP_EN 3'h4
`define DSMP_ST_QS_ACT 3'h5
`define DSMP_ST_FR_ACT 3'h6
`define DSMP_ST_FAULT 3'h7

// Low seven status bits per state
`define DSMP_ENC_NOT_RDY 7'h00
`define DSMP_ENC_SOD 7'h50
`define DSMP_ENC_RTSO 7'h31
`define DSMP_ENC_SW_ON 7'h33
`define DSMP_ENC_OP_EN 7'h37
`define DSMP_ENC_QS_ACT 7'h17
`define DSMP_ENC_FR_ACT 7'h0f
`define DSMP_ENC_FAULT 7'h08

// Mode codes
`define DSMP_MODE_PP 8'h01
`define DSMP_MODE_VL 8'h02
`define DSMP_MODE_PV 8'h03
`define DSMP_MODE_HM 8'h06
`define DSMP_MODE_IP 8'h07
`define DSMP_MODE_CSP 8'h08
`define DSMP_MODE_CSV 8'h09
`define DSMP_MODE_CST 8'h0a

// Control source setting for fieldbus profile control
`define DSMP_SRC_FIELDBUS 8'h05

// Quick stop option codes that end in target reached
`define DSMP_QS_OPT_LO 4'h5
`define DSMP_QS_OPT_HI 4'h8

`endif

//--- dv/dsmp_ctrl_asserts.sv
// Concurrent checks on status word, mode display and setpoint start
`timescale 1ns/100ps
module dsmp_ctrl_asserts (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Watched ports
    input wire logic [2:0] drv_state,
    input wire logic fault_cond,
    input wire logic warn_cond,
    input wire logic [7:0] control_source_selector,
    input wire logic cw_processed,
    input wire logic traj_start,
    input wire logic traj_halt,
    input wire logic move_busy,
    input wire logic [15:0] status_word,
    input wire logic [7:0] mode_disp
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    logic rem_q;
    // Remote cause delayed by the status register stage
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rem_q <= 1'b0;
        end else begin
            rem_q <= control_source_selector == 8'h05 && cw_processed;
        end
    end
    sequence s_take;
        traj_start && $rose(move_busy);
    endsequence
    sequence s_arrive;
        $fell(move_busy) && mode_disp == 8'h01 && drv_state == 3'h4 && !traj_halt;
    endsequence
    a_qstop_low: assert property (drv_state == 3'h5 |=> !status_word[5])
        else $error("quick stop bit not low");
    a_ready_bits: assert property (drv_state == 3'h4 |=> status_word[2:0] == 3'b111)
        else $error("ready bits not set");
    a_fault_bit: assert property (fault_cond |=> status_word[3])
        else $error("fault bit not set");
    a_warn_follow: assert property (status_word[7] == $past(warn_cond))
        else $error("warning bit wrong");
    a_remote_bit: assert property (status_word[9] == rem_q)
        else $error("remote bit wrong");
    a_mode_hold: assert property (drv_state != 3'h4 |=> $stable(mode_disp))
        else $error("mode changed outside operation enabled");
    a_take_ack: assert property (s_take |=> status_word[12])
        else $error("setpoint ack missing");
    a_arrive_reached: assert property (s_arrive |=> status_word[10])
        else $error("target reached missing");
endmodule

bind dsmp_ctrl dsmp_ctrl_asserts chk_i (.ref_clk, .arst_n, .drv_state, .fault_cond,
    .warn_cond, .control_source_selector, .cw_processed, .traj_start, .traj_halt,
    .move_busy, .status_word, .mode_disp);

//--- dv/dsmp_master.sv
// Fieldbus master model: object accesses and the setpoint handshake
`timescale 1ns/100ps
module dsmp_master (
    // Clock and status feedback
    input wire logic ref_clk,
    input wire logic [15:0] status_word,
    // Object bus requests
    output logic od_wr,
    output logic od_rd,
    output logic [15:0] od_index,
    output logic [7:0] od_sub,
    output logic [31:0] od_wdata
);
    initial begin
        {od_wr, od_rd} = 2'b00;
        {od_index, od_sub, od_wdata} = '1;
    end
    task automatic acc(input logic rd, input logic [15:0] idx, input logic [7:0] sub,
            input logic [31:0] d);
        @(negedge ref_clk);
        {od_wr, od_rd} = {!rd, rd};
        {od_index, od_sub, od_wdata} = {idx, sub, d};
        @(negedge ref_clk);
        {od_wr, od_rd} = 2'b00;
        // Released fields must not keep showing the old request
        {od_index, od_sub, od_wdata} = ~{idx, sub, d};
        @(negedge ref_clk);
    endtask
    task automatic set_sp(input logic [31:0] t, input logic [15:0] cw, output logic ok);
        acc(1'b0, 16'h607a, 8'h00, t);
        acc(1'b0, 16'h6040, 8'h00, cw | 16'h0010);
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(negedge ref_clk);
            ok = status_word[12] === 1'b1;
        end
        acc(1'b0, 16'h6040, 8'h00, cw);
    endtask
endmodule

//--- dv/tb.sv
// Self-checking bench for status word, mode selection and setpoints
`timescale 1ns/100ps
`include "dsmp_regs.vh"
module tb;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic od_wr, od_rd, od_ack, od_err, fault_cond, warn_cond, volt_on, cw_processed, qs_done;
    logic limit_in, traj_at_target, standstill, follow_err, vel_reached, zero_speed, slip_err;
    logic home_done, home_err, ip_active, tgt_ignored, traj_start, traj_halt, move_busy, ok;
    logic [2:0] drv_state;
    logic [3:0] qs_option;
    logic [7:0] od_sub, control_source_selector, traj_dir_inv, mode_disp;
    logic [15:0] od_index, status_word;
    logic [31:0] od_wdata, od_rdata, act_pos, traj_target, traj_vel, traj_acc, traj_dec;
    logic [31:0] traj_qs_dec, d, t1, t2, wv [7];
    logic [33:0] ex;
    logic [33:0] q [$];
    logic [6:0] enc [8] = '{`DSMP_ENC_NOT_RDY, `DSMP_ENC_SOD, `DSMP_ENC_RTSO, `DSMP_ENC_SW_ON,
        `DSMP_ENC_OP_EN, `DSMP_ENC_QS_ACT, `DSMP_ENC_FR_ACT, `DSMP_ENC_FAULT};
    logic [15:0] rw_idx [7] = '{16'h607a, 16'h6081, 16'h6083, 16'h6084, 16'h6085, 16'h607d,
        16'h607e};
    logic [15:0] bad [5] = '{16'h6041, 16'h6061, 16'h6064, 16'h1234, 16'h607d};
    int fail_count = 0;
    int n_checks = 0;
    int cyc = 0;

    dsmp_ctrl uut (.*);
    dsmp_master m (.*);

    always #4 ref_clk = ~ref_clk;

    task automatic test_done();
        if (fail_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic c, input string s);
        n_checks++;
        if (c !== 1'b1) begin
            fail_count++;
            $display("MISMATCH %0t %s", $time, s);
        end
    endtask
    // Expected answer is queued before the request goes out
    task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] v,
            input logic e);
        q.push_back({e, 1'b0, v});
        m.acc(1'b0, i, s, v);
    endtask
    task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] v);
        q.push_back({1'b0, 1'b1, v});
        m.acc(1'b1, i, s, 32'h0000_0000);
    endtask
    task automatic sp(input logic [31:0] t, input logic [15:0] cw);
        repeat (3) q.push_back(34'h0_0000_0000);
        m.set_sp(t, cw, ok);
        chk(ok, "no setpoint ack");
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    always @(negedge ref_clk) begin
        if (od_ack === 1'b1 || od_err === 1'b1) begin
            ex = q.size() > 0 ? q.pop_front() : 34'h3_ffff_ffff;
            chk(od_err === ex[33] && (!ex[32] || od_rdata === ex[31:0]), "object answer");
        end
    end
    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        {fault_cond, warn_cond, cw_processed, qs_done, limit_in, traj_at_target, standstill} = '0;
        {follow_err, vel_reached, zero_speed, slip_err, home_done, home_err, ip_active} = '0;
        {tgt_ignored, drv_state, qs_option, control_source_selector, act_pos, volt_on} = '0;
        d = $urandom(32'hd208);
        wt(20);
        arst_n = 1'b1;
        chk(status_word === 16'h0000 && mode_disp === 8'h00, "reset values");
        foreach (rw_idx[i]) begin
            d = (i == 6) ? ($urandom & 32'h0000_00ff) : $urandom;
            wv[i] = d;
            wr(rw_idx[i], 8'h01, d, 1'b0);
            rd(rw_idx[i], 8'h01, d);
        end
        chk({traj_vel, traj_acc, traj_dec, traj_qs_dec, traj_dir_inv} ===
            {wv[1], wv[2], wv[3], wv[4], wv[6][7:0]}, "object outputs");
        wr(16'h607d, 8'h02, d, 1'b0);
        rd(16'h607d, 8'h02, d);
        foreach (bad[i]) wr(bad[i], 8'h03, 32'h0000_0000, 1'b1);
        act_pos = $urandom;
        rd(16'h6064, 8'h00, act_pos);
        for (int s = 0; s < 8; s++) begin
            drv_state = 3'(s);
            volt_on = enc[s][4];
            fault_cond = s > 5;
            wt(2);
            chk(status_word[6:0] === enc[s], "state bits");
        end
        {fault_cond, warn_cond, volt_on, drv_state} = {3'b011, 3'h4};
        wt(2);
        chk(status_word[7] === 1'b1 && status_word[6:0] === enc[4], "warning");
        warn_cond = 1'b0;
        for (int k = 0; k < 4; k++) begin
            control_source_selector = k[0] ? 8'h05 : 8'($urandom % 5);
            cw_processed = k[1];
            wt(2);
            chk(status_word[9] === (k == 3), "remote bit");
        end
        for (int c = 1; c <= 10; c++) begin
            wr(16'h6060, 8'h00, 32'(c), c == 4 || c == 5);
            if (c != 4 && c != 5) rd(16'h6061, 8'h00, 32'(c));
        end
        wr(16'h6061, 8'h00, 32'h0000_0001, 1'b1);
        drv_state = 3'h3;
        wr(16'h6060, 8'h00, 32'h0000_0003, 1'b0);
        wt(2);
        chk(mode_disp === 8'h0a, "mode switched outside enabled");
        drv_state = 3'h4;
        wt(2);
        chk(mode_disp === 8'h03, "mode not switched");
        {slip_err, zero_speed, vel_reached} = 3'b111;
        wt(2);
        chk(status_word[13:10] === 4'b1101, "velocity mode bits");
        {slip_err, zero_speed, vel_reached} = 3'b000;
        wr(16'h6060, 8'h00, 32'h0000_0006, 1'b0);
        for (int h = 1; h < 3; h++) begin
            {home_err, home_done} = 2'(h);
            wt(2);
            chk(status_word[13:12] === 2'(h), "homing bits");
        end
        {home_err, home_done, limit_in} = 3'b001;
        wt(2);
        chk(status_word[11] === 1'b1, "limit bit");
        limit_in = 1'b0;
        wr(16'h6060, 8'h00, 32'h0000_0001, 1'b0);
        t1 = $urandom;
        t2 = $urandom % 1000;
        sp(t1, 16'h0000);
        chk(traj_target === t1 && move_busy === 1'b1 && status_word[10] === 1'b0, "abs");
        wt(3);
        chk(status_word[12] === 1'b0, "ack not cleared");
        sp(t2, 16'h0040);
        chk(traj_target === t1, "queued setpoint taken early");
        traj_at_target = 1'b1;
        wt(1);
        traj_at_target = 1'b0;
        wt(3);
        chk(traj_target === t1 + t2 && move_busy === 1'b1, "queued move");
        t2 = $urandom;
        sp(t2, 16'h0020);
        chk(traj_target === t2, "immediate change");
        traj_at_target = 1'b1;
        wt(3);
        chk(move_busy === 1'b0 && status_word[10] === 1'b1, "arrival");
        traj_at_target = 1'b0;
        sp($urandom, 16'h0000);
        wr(16'h6040, 8'h00, 32'h0000_0100, 1'b0);
        wt(2);
        chk(traj_halt === 1'b1 && status_word[10] === 1'b0, "halt braking");
        standstill = 1'b1;
        wt(2);
        chk(status_word[10] === 1'b1, "halt standstill");
        standstill = 1'b0;
        for (int o = 4; o <= 8; o++) begin
            {drv_state, qs_option, qs_done} = {3'h4, 4'(o), 1'b0};
            wt(1);
            {drv_state, qs_done} = {3'h5, 1'b1};
            wt(2);
            chk(status_word[10] === (o > 4), "quick stop end");
        end
        test_done();
    end
endmodule
